// [src/acfm_pkg.sv]
/*
  Constants shared by the IPv6 access control entry matcher: register
  offsets, field positions, reset values and the criterion mode codes.
  Assumes nothing of its surroundings.
*/
package acfm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPORT = 8'h04;
  localparam logic [7:0] OFF_DPORT = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_TOS = 8'h10;
  localparam logic [7:0] OFF_ICMP = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_DENY = 1;
  localparam int CTRL_SRC = 2;
  localparam int CTRL_DST = 4;
  localparam int CTRL_TOS = 6;
  localparam int CTRL_ICMP = 8;
  localparam int CTRL_CODE = 10;
  localparam int CTRL_W = 11;
  localparam int PORT_HI = 16;
  localparam int TOS_PREC = 8;
  localparam int ICMP_LIST = 8;
  localparam int ICMP_CODE = 16;
  localparam int STAT_HIT = 16;
  localparam int STAT_DROP = 17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] RST_CTRL = 11'h000;
  localparam logic [31:0] RST_PORT = 32'hffff_0000;
  localparam logic [11:0] RST_FLAGS = 12'h000;
  localparam logic [10:0] RST_TOS = 11'h000;
  localparam logic [23:0] RST_ICMP = 24'h00_0000;
  localparam logic [15:0] RST_CNT = 16'h0000;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PM_ANY = 2'h0;
  localparam logic [1:0] PM_SINGLE = 2'h1;
  localparam logic [1:0] PM_RANGE = 2'h2;
  localparam logic [1:0] FM_DC = 2'h0;
  localparam logic [1:0] FM_SET = 2'h1;
  localparam logic [1:0] FM_UNSET = 2'h2;
  localparam logic [1:0] TM_ANY = 2'h0;
  localparam logic [1:0] TM_DSCP = 2'h1;
  localparam logic [1:0] TM_PREC = 2'h2;
  localparam logic [1:0] IM_ANY = 2'h0;
  localparam logic [1:0] IM_LIST = 2'h1;
  localparam logic [1:0] IM_PROTO = 2'h2;

  // Predefined list of ICMP types, selected by a 3-bit index.
  localparam logic [7:0] ICMP_TAB [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                         8'h80, 8'h81, 8'h85, 8'h87};

  typedef enum logic [1:0] {ACFM_IDLE, ACFM_WR, ACFM_RD} acfm_bus_t;

endpackage

// [src/acfm_port_if.sv]
/*
  Carrier between the matcher and one layer-4 port comparator.
  Assumes the matcher drives the criterion and the comparator the result.
*/
`timescale 1ns/1ps
interface acfm_port_if;
  logic [1:0] mode;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] val;
  logic ok;
  modport ctl (output mode, output lo, output hi, output val, input ok);
  modport cmp (input mode, input lo, input hi, input val, output ok);
endinterface

// [src/acfm_port_cmp.sv]
/*
  Layer-4 port criterion: any, single value or inclusive range.
  Assumes configuration and frame port arrive on the same clock.
*/
`timescale 1ns/1ps
module acfm_port_cmp (
  acfm_port_if.cmp p
);

  always_comb begin
    case (p.mode)
      acfm_pkg::PM_ANY: p.ok = 1'b1;
      acfm_pkg::PM_SINGLE: p.ok = (p.val == p.lo);
      acfm_pkg::PM_RANGE: p.ok = (p.val >= p.lo) && (p.val <= p.hi);
      default: p.ok = 1'b0;
    endcase
  end

endmodule // acfm_port_cmp

// [src/acfm_flag_cmp.sv]
/*
  TCP flag criteria, two mode bits per flag, URG in the top pair down to
  FIN in the bottom pair. Assumes flags[5:0] is URG,ACK,PSH,RST,SYN,FIN.
*/
`timescale 1ns/1ps
module acfm_flag_cmp (
  input wire logic [11:0] cfg,
  input wire logic [5:0] flags,
  input wire logic is_tcp,
  output logic ok
);

  logic [5:0] bit_ok;
  logic [5:0] dc;

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_flag
      assign dc[i] = (cfg[2*i+1:2*i] == acfm_pkg::FM_DC);
      assign bit_ok[i] = dc[i] ||
        (cfg[2*i+1:2*i] == acfm_pkg::FM_SET && flags[i]) ||
        (cfg[2*i+1:2*i] == acfm_pkg::FM_UNSET && !flags[i]);
    end
  endgenerate

  // A non-TCP frame only passes when every flag is don't-care.
  assign ok = (&bit_ok) && (is_tcp || (&dc));

endmodule // acfm_flag_cmp

// [src/acfm_matcher.sv]
/*
  One IPv6 access control entry: configuration registers on an AHB-Lite
  slave, the per-field comparators and the registered hit and action.
  Assumes the frame fields come from the ingress parser on ref_clk, held
  for the one cycle in which frm_valid is high.
*/
`timescale 1ns/1ps
module acfm_matcher (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic frm_valid,
  input wire logic [15:0] frm_sport,
  input wire logic [15:0] frm_dport,
  input wire logic [5:0] frm_flags,
  input wire logic [7:0] frm_tclass,
  input wire logic [7:0] frm_icmp_type,
  input wire logic [7:0] frm_icmp_code,
  input wire logic frm_is_tcp,
  input wire logic frm_is_icmp,
  output logic res_valid,
  output logic res_hit,
  output logic res_forward,
  output logic res_learn,
  output logic res_drop
);

  // ----------------------------------------------------------------
  // Configuration and status storage
  // ----------------------------------------------------------------
  logic [acfm_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0] sport_r;
  logic [31:0] dport_r;
  logic [11:0] flags_r;
  logic [10:0] tos_r;
  logic [23:0] icmp_r;
  logic [15:0] hit_cnt_r;
  logic last_hit_r;
  logic last_drop_r;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  acfm_pkg::acfm_bus_t bus_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic take;
  logic wr_en;
  logic [31:0] rd_nxt;

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  logic res_valid_r;
  logic res_hit_r;
  logic res_forward_r;
  logic res_learn_r;
  logic res_drop_r;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY are ignored.
  assign take = hsel && hready && htrans[1];
  assign wr_en = (bus_r == acfm_pkg::ACFM_WR);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_r <= acfm_pkg::ACFM_IDLE;
    end else if (take) begin
      bus_r <= hwrite ? acfm_pkg::ACFM_WR : acfm_pkg::ACFM_RD;
    end else if (hreadyout_r) begin
      bus_r <= acfm_pkg::ACFM_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= 8'h00;
    end else if (take) begin
      addr_r <= haddr[7:0];
    end
  end

  // Reads take one wait state so that the data are sampled after any
  // write still in its data phase has landed.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout_r <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (bus_r == acfm_pkg::ACFM_RD && !hreadyout_r) begin
      hrdata_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= acfm_pkg::RST_CTRL;
    end else if (wr_en && addr_r == acfm_pkg::OFF_CTRL) begin
      ctrl_r <= hwdata[acfm_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sport_r <= acfm_pkg::RST_PORT;
    end else if (wr_en && addr_r == acfm_pkg::OFF_SPORT) begin
      sport_r <= hwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dport_r <= acfm_pkg::RST_PORT;
    end else if (wr_en && addr_r == acfm_pkg::OFF_DPORT) begin
      dport_r <= hwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= acfm_pkg::RST_FLAGS;
    end else if (wr_en && addr_r == acfm_pkg::OFF_FLAGS) begin
      flags_r <= hwdata[11:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tos_r <= acfm_pkg::RST_TOS;
    end else if (wr_en && addr_r == acfm_pkg::OFF_TOS) begin
      tos_r <= hwdata[10:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      icmp_r <= acfm_pkg::RST_ICMP;
    end else if (wr_en && addr_r == acfm_pkg::OFF_ICMP) begin
      icmp_r <= hwdata[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Bits above each register's width and unmapped offsets read zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (addr_r)
      acfm_pkg::OFF_CTRL: rd_nxt[acfm_pkg::CTRL_W-1:0] = ctrl_r;
      acfm_pkg::OFF_SPORT: rd_nxt = sport_r;
      acfm_pkg::OFF_DPORT: rd_nxt = dport_r;
      acfm_pkg::OFF_FLAGS: rd_nxt[11:0] = flags_r;
      acfm_pkg::OFF_TOS: rd_nxt[10:0] = tos_r;
      acfm_pkg::OFF_ICMP: rd_nxt[23:0] = icmp_r;
      acfm_pkg::OFF_STAT: begin
        rd_nxt[15:0] = hit_cnt_r;
        rd_nxt[acfm_pkg::STAT_HIT] = last_hit_r;
        rd_nxt[acfm_pkg::STAT_DROP] = last_drop_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Port criteria
  // ----------------------------------------------------------------
  acfm_port_if src_if ();
  acfm_port_if dst_if ();

  assign src_if.mode = ctrl_r[acfm_pkg::CTRL_SRC +: 2];
  assign src_if.lo = sport_r[15:0];
  assign src_if.hi = sport_r[acfm_pkg::PORT_HI +: 16];
  assign src_if.val = frm_sport;
  assign dst_if.mode = ctrl_r[acfm_pkg::CTRL_DST +: 2];
  assign dst_if.lo = dport_r[15:0];
  assign dst_if.hi = dport_r[acfm_pkg::PORT_HI +: 16];
  assign dst_if.val = frm_dport;

  acfm_port_cmp u_src (
    .p (src_if.cmp)
  );

  acfm_port_cmp u_dst (
    .p (dst_if.cmp)
  );

  // ----------------------------------------------------------------
  // TCP flag criteria
  // ----------------------------------------------------------------
  logic flags_ok;

  acfm_flag_cmp u_flags (
    .cfg (flags_r),
    .flags (frm_flags),
    .is_tcp (frm_is_tcp),
    .ok (flags_ok)
  );

  // ----------------------------------------------------------------
  // Type of service criterion
  // ----------------------------------------------------------------
  logic tos_ok;

  always_comb begin
    case (ctrl_r[acfm_pkg::CTRL_TOS +: 2])
      acfm_pkg::TM_ANY: tos_ok = 1'b1;
      acfm_pkg::TM_DSCP: tos_ok = (frm_tclass[7:2] == tos_r[5:0]);
      acfm_pkg::TM_PREC: tos_ok = (frm_tclass[7:5] == tos_r[acfm_pkg::TOS_PREC +: 3]);
      default: tos_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // ICMP criteria
  // ----------------------------------------------------------------
  logic icmp_ok;
  logic code_ok;
  logic [7:0] list_type;

  assign list_type = acfm_pkg::ICMP_TAB[icmp_r[acfm_pkg::ICMP_LIST +: 3]];

  // Non-ICMP frames fail any ICMP criterion that is not don't-care.
  always_comb begin
    case (ctrl_r[acfm_pkg::CTRL_ICMP +: 2])
      acfm_pkg::IM_ANY: icmp_ok = 1'b1;
      acfm_pkg::IM_LIST: icmp_ok = frm_is_icmp && (frm_icmp_type == list_type);
      acfm_pkg::IM_PROTO: icmp_ok = frm_is_icmp && (frm_icmp_type == icmp_r[7:0]);
      default: icmp_ok = 1'b0;
    endcase
  end

  always_comb begin
    if (!ctrl_r[acfm_pkg::CTRL_CODE]) begin
      code_ok = 1'b1;
    end else begin
      code_ok = frm_is_icmp && (frm_icmp_code == icmp_r[acfm_pkg::ICMP_CODE +: 8]);
    end
  end

  // ----------------------------------------------------------------
  // Hit and action
  // ----------------------------------------------------------------
  logic hit;
  logic deny;

  assign hit = ctrl_r[acfm_pkg::CTRL_EN] && src_if.ok && dst_if.ok && flags_ok &&
               tos_ok && icmp_ok && code_ok;
  assign deny = ctrl_r[acfm_pkg::CTRL_DENY];

  // A miss asserts neither forward nor drop; the verdict is left to
  // other entries or the default policy.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid_r <= 1'b0;
      res_hit_r <= 1'b0;
      res_forward_r <= 1'b0;
      res_learn_r <= 1'b0;
      res_drop_r <= 1'b0;
    end else begin
      res_valid_r <= frm_valid;
      res_hit_r <= frm_valid && hit;
      res_forward_r <= frm_valid && hit && !deny;
      res_learn_r <= frm_valid && hit && !deny;
      res_drop_r <= frm_valid && hit && deny;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hit_cnt_r <= acfm_pkg::RST_CNT;
    end else if (frm_valid && hit) begin
      hit_cnt_r <= hit_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_hit_r <= 1'b0;
      last_drop_r <= 1'b0;
    end else if (frm_valid) begin
      last_hit_r <= hit;
      last_drop_r <= hit && deny;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign res_valid = res_valid_r;
  assign res_hit = res_hit_r;
  assign res_forward = res_forward_r;
  assign res_learn = res_learn_r;
  assign res_drop = res_drop_r;

endmodule // acfm_matcher

// [bench/acfm_monitor.sv]
/*
  Checker for the access control entry matcher, watching its top ports.
  Assumes one clock, ref_clk, and the asynchronous reset arst_n.
*/
`timescale 1ns/1ps
module acfm_matcher_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frm_valid,
  input wire logic res_valid,
  input wire logic res_hit,
  input wire logic res_forward,
  input wire logic res_learn,
  input wire logic res_drop
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_result_one_cycle: assert property (frm_valid |=> res_valid)
    else $error("no result one cycle after a frame");
  a_result_no_spur: assert property (!frm_valid |=> !res_valid)
    else $error("result without a frame");
  a_hit_with_valid: assert property (res_hit |-> res_valid)
    else $error("hit outside a result cycle");
  a_permit_fwd_learn: assert property (res_forward |-> res_learn && res_hit && !res_drop)
    else $error("forward without learn or hit");
  a_learn_fwd_tie: assert property (res_learn |-> res_forward)
    else $error("learn without forward");
  a_deny_drop_only: assert property (res_drop |-> res_hit && !res_forward)
    else $error("drop without hit or with forward");
  a_hit_has_action: assert property (res_hit |-> res_forward != res_drop)
    else $error("hit without exactly one action");
  a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");

  c_permit: cover property (res_hit && res_forward);
  c_deny: cover property (res_drop);
  c_miss: cover property (res_valid && !res_hit);
endmodule // acfm_matcher_chk

bind acfm_matcher acfm_matcher_chk u_chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .frm_valid(frm_valid),
  .res_valid(res_valid),
  .res_hit(res_hit),
  .res_forward(res_forward),
  .res_learn(res_learn),
  .res_drop(res_drop)
);

// [bench/acfm_frame_src.sv]
/*
  Model of the ingress parser: presents one frame for one cycle.
  Assumes the caller stays in step with ref_clk between frames.
*/
`timescale 1ns/1ps
module acfm_frame_src (
  input wire logic ref_clk,
  output logic frm_valid,
  output logic [15:0] frm_sport,
  output logic [15:0] frm_dport,
  output logic [5:0] frm_flags,
  output logic [7:0] frm_tclass,
  output logic [7:0] frm_icmp_type,
  output logic [7:0] frm_icmp_code,
  output logic frm_is_tcp,
  output logic frm_is_icmp
);
  logic [63:0] fields_r;

  assign {frm_sport, frm_dport, frm_flags, frm_tclass, frm_icmp_type, frm_icmp_code, frm_is_tcp, frm_is_icmp} = fields_r;

  initial begin
    frm_valid = 1'b0;
    fields_r = 64'h0;
  end

  // Fields are inverted once released so a stale value can never match.
  task automatic send(input logic [63:0] f);
    @(posedge ref_clk);
    frm_valid <= 1'b1;
    fields_r <= f;
    @(posedge ref_clk);
    frm_valid <= 1'b0;
    fields_r <= ~f;
  endtask
endmodule // acfm_frame_src

// [bench/tb.sv]
/*
  Self-checking bench for the matcher: AHB-Lite register access and frames.
  Assumes hready is the matcher's own hreadyout, as the only slave.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk, arst_n, hsel, hwrite, hreadyout, hresp, deny;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, pr;
  logic [2:0] hsize;
  logic frm_valid, frm_is_tcp, frm_is_icmp;
  logic [15:0] frm_sport, frm_dport, sp, dp, n_hit;
  logic [5:0] frm_flags, fl;
  logic [7:0] frm_tclass, frm_icmp_type, frm_icmp_code, tc, ty, cd;
  logic res_valid, res_hit, res_forward, res_learn, res_drop;
  int n_fail, n_tests;

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  acfm_frame_src u_src (.ref_clk(ref_clk), .frm_valid(frm_valid), .frm_sport(frm_sport), .frm_dport(frm_dport),
    .frm_flags(frm_flags), .frm_tclass(frm_tclass), .frm_icmp_type(frm_icmp_type), .frm_icmp_code(frm_icmp_code),
    .frm_is_tcp(frm_is_tcp), .frm_is_icmp(frm_is_icmp));

  acfm_matcher u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .frm_valid(frm_valid), .frm_sport(frm_sport), .frm_dport(frm_dport), .frm_flags(frm_flags),
    .frm_tclass(frm_tclass), .frm_icmp_type(frm_icmp_type), .frm_icmp_code(frm_icmp_code),
    .frm_is_tcp(frm_is_tcp), .frm_is_icmp(frm_is_icmp), .res_valid(res_valid), .res_hit(res_hit),
    .res_forward(res_forward), .res_learn(res_learn), .res_drop(res_drop));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // A stuck slave would hang the bus, so every wait is bounded.
  task automatic wrdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      chk("hready", 32'h1, 32'h0);
      end_sim;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    wrdy;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic cf(input logic [31:0] c);
    wr(acfm_pkg::OFF_CTRL, c);
    deny = c[1];
  endtask

  task automatic fr(input logic h);
    u_src.send({sp, dp, fl, tc, ty, cd, pr});
    #1;
    n_hit = n_hit + {15'h0, h};
    chk("result", {27'h0, 1'b1, h, h & !deny, h & !deny, h & deny},
      {27'h0, res_valid, res_hit, res_forward, res_learn, res_drop});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    deny = 1'b0;
    n_fail = 0;
    n_tests = 0;
    n_hit = 16'h0;
    sp = 16'h64;
    dp = 16'hc8;
    fl = 6'h0;
    tc = 8'h0;
    ty = 8'h0;
    cd = 8'h0;
    pr = 2'h2;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdc("ctrl", acfm_pkg::OFF_CTRL, 32'h0);
    rdc("sport", acfm_pkg::OFF_SPORT, 32'hffff_0000);
    rdc("dport", acfm_pkg::OFF_DPORT, 32'hffff_0000);
    rdc("flags", acfm_pkg::OFF_FLAGS, 32'h0);
    rdc("stat", acfm_pkg::OFF_STAT, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    rdc("unmapped", 8'h1c, 32'h0);
    fr(1'b0);
    cf(32'h1);
    fr(1'b1);
    wr(acfm_pkg::OFF_SPORT, 32'h012c_0064);
    cf(32'h9);
    sp = 16'h63;
    fr(1'b0);
    sp = 16'h12c;
    fr(1'b1);
    sp = 16'h12d;
    fr(1'b0);
    sp = 16'h64;
    fr(1'b1);
    wr(acfm_pkg::OFF_DPORT, 32'h0000_00c8);
    cf(32'h11);
    fr(1'b1);
    dp = 16'hc9;
    fr(1'b0);
    dp = 16'hc8;
    cf(32'h19);
    fr(1'b1);
    sp = 16'h12d;
    fr(1'b0);
    sp = 16'h64;
    wr(acfm_pkg::OFF_DPORT, 32'hffff_fff0);
    cf(32'h21);
    dp = 16'hffff;
    fr(1'b1);
    dp = 16'hffef;
    fr(1'b0);
    wr(acfm_pkg::OFF_SPORT, 32'h0000_0064);
    cf(32'h5);
    fr(1'b1);
    sp = 16'h65;
    fr(1'b0);
    sp = 16'h64;
    cf(32'hd);
    fr(1'b0);
    cf(32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(acfm_pkg::OFF_FLAGS, 32'h1 << (2 * i));
      fl = 6'h1 << i;
      fr(1'b1);
      pr = 2'h1;
      fr(1'b0);
      pr = 2'h2;
      fl = ~(6'h1 << i);
      fr(1'b0);
      wr(acfm_pkg::OFF_FLAGS, 32'h2 << (2 * i));
      fr(1'b1);
      fl = 6'h1 << i;
      fr(1'b0);
    end
    wr(acfm_pkg::OFF_FLAGS, 32'h3);
    fr(1'b0);
    wr(acfm_pkg::OFF_FLAGS, 32'h0);
    wr(acfm_pkg::OFF_TOS, 32'h2a);
    cf(32'h41);
    tc = 8'ha8;
    fr(1'b1);
    tc = 8'hac;
    fr(1'b0);
    wr(acfm_pkg::OFF_TOS, 32'h500);
    cf(32'h81);
    tc = 8'hbf;
    fr(1'b1);
    tc = 8'hc0;
    fr(1'b0);
    cf(32'hc1);
    fr(1'b0);
    pr = 2'h1;
    cf(32'h101);
    for (int i = 0; i < 8; i++) begin
      wr(acfm_pkg::OFF_ICMP, 32'h100 * i);
      ty = acfm_pkg::ICMP_TAB[i];
      fr(1'b1);
      ty = ~ty;
      fr(1'b0);
    end
    wr(acfm_pkg::OFF_ICMP, 32'h7f_00ff);
    cf(32'h201);
    ty = 8'hff;
    fr(1'b1);
    ty = 8'hfe;
    fr(1'b0);
    ty = 8'hff;
    pr = 2'h2;
    fr(1'b0);
    pr = 2'h1;
    cf(32'h301);
    fr(1'b0);
    cf(32'h401);
    cd = 8'h7f;
    fr(1'b1);
    pr = 2'h2;
    fr(1'b0);
    pr = 2'h1;
    cd = 8'h80;
    fr(1'b0);
    cf(32'h1);
    fr(1'b1);
    cf(32'h3);
    fr(1'b1);
    rdc("stat", acfm_pkg::OFF_STAT, {14'h0, 2'h3, n_hit});
    end_sim;
  end
endmodule // tb
